// *** hdl/serial_rate_pkg.sv ***
// Constants for the serial rate and control block.
// Assumes a plain register port with one-cycle read latency.
package serial_rate_pkg;
    // Register offsets on the plain register port
    localparam logic [3:0] OFF_CHAR_DATA = 4'h0;
    localparam logic [3:0] OFF_RATE_SELECT = 4'h1;
    localparam logic [3:0] OFF_RX_EXT_DIV = 4'h2;
    localparam logic [3:0] OFF_TX_EXT_DIV = 4'h3;
    localparam logic [3:0] OFF_CONTROL = 4'h4;
    localparam logic [3:0] OFF_STATUS = 4'h5;
    localparam logic [3:0] OFF_IRQ_MASK = 4'h6;
    // Reset values
    localparam logic [7:0] RATE_SELECT_RST = 8'h00;
    localparam logic [7:0] EXT_DIV_RST = 8'h00;
    localparam logic [7:0] STATUS_RST = 8'h03;
    // Field positions of rate_select
    localparam int PRESCALE_LSB = 6;
    localparam int TX_RATE_LSB = 3;
    localparam int RX_RATE_LSB = 0;
    // Control bits
    localparam int CTL_BREAK_BIT = 0;
    localparam int CTL_MUTE_BIT = 1;
    // Status bits
    localparam int ST_TX_EMPTY_BIT = 0;
    localparam int ST_RX_FULL_BIT = 1;
    // Fixed stage ahead of the extended divider
    localparam logic [3:0] SIXTEEN_DIV_TOP = 4'hF;
    // Widest conventional divide: 13 * 128
    localparam int CONV_CNT_W = 11;
    // Character access state
    typedef enum logic [1:0] {
        ACC_IDLE = 2'b00,
        ACC_STATUS_SEEN = 2'b01
    } access_e;
endpackage

// *** hdl/serial_rate_ctl.sv ***
// Serial rate generators, mute and break control, data holding registers.
// Assumes an outer shift engine that reports load/receive/wake/word events.
//
// Summary of operation
// - Mute bit set by software, cleared on wake
// - Break bit drives break request while set
// - Set-then-clear break sends one break word
// - Data address: writes tx holding, reads rx
// - Prescale code 01/10/11 divides 3/4/13
// - Tx divide factor is two to the code
// - Rx divide factor is two to the code
// - Conventional rate is prescale times path factor
// - Nonzero rx extended value divides sixteen stage
// - Nonzero tx extended value divides sixteen stage
// - Extended dividers reset to zero, unused
// - Extended 35, unity factors gives near 44600 at 25 MHz
// - Tx empty set on load, status-then-write clears
// - Rx full set on receive, status-then-read clears
`timescale 1ns/1ps
module serial_rate_ctl (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_reset,
    // Register port
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Shift engine side
    input wire logic i_tx_load,
    input wire logic i_rx_done,
    input wire logic [7:0] i_rx_byte,
    input wire logic i_wake,
    input wire logic i_word_end,
    output logic [7:0] o_tx_byte,
    output logic o_tx_rate_tick,
    output logic o_rx_rate_tick,
    output logic o_break_level,
    output logic o_break_once,
    output logic o_mute,
    // Interrupt
    output logic o_irq
);
    import serial_rate_pkg::*;

    logic [7:0] rate_select_ff;
    logic [7:0] rx_ext_div_ff;
    logic [7:0] tx_ext_div_ff;
    logic [7:0] tx_holding_ff;
    logic [7:0] rx_holding_ff;
    logic [7:0] rdata_ff;
    logic [1:0] status_ff;
    logic [1:0] mask_ff;
    logic mute_ff;
    logic break_ff;
    logic break_pend_ff;
    logic break_once_ff;
    access_e acc_ff;
    logic [CONV_CNT_W-1:0] tx_cnt_ff;
    logic [CONV_CNT_W-1:0] rx_cnt_ff;
    logic [3:0] sixteen_ff;
    logic [7:0] tx_ext_cnt_ff;
    logic [7:0] rx_ext_cnt_ff;
    logic tx_tick_ff;
    logic rx_tick_ff;

    // Prescale factor from the two-bit code
    function automatic logic [3:0] stage_one_factor(input logic [1:0] code);
        case (code)
            2'b01: stage_one_factor = 4'h3;
            2'b10: stage_one_factor = 4'h4;
            2'b11: stage_one_factor = 4'hD;
            default: stage_one_factor = 4'h1;
        endcase
    endfunction

    // Total conventional divide minus one: prescale shifted by path code
    function automatic logic [CONV_CNT_W-1:0] conv_top(input logic [1:0] pre,
                                                       input logic [2:0] code);
        logic [CONV_CNT_W-1:0] total;
        total = CONV_CNT_W'(stage_one_factor(pre)) << code;
        conv_top = total - CONV_CNT_W'(1);
    endfunction

    logic [1:0] pre_sel;
    logic [2:0] tx_sel;
    logic [2:0] rx_sel;
    logic tx_ext_on;
    logic rx_ext_on;
    logic sixteen_wrap;
    logic st_hit;
    logic rd_data;
    logic wr_data;
    assign pre_sel = rate_select_ff[PRESCALE_LSB +: 2];
    assign tx_sel = rate_select_ff[TX_RATE_LSB +: 3];
    assign rx_sel = rate_select_ff[RX_RATE_LSB +: 3];
    assign tx_ext_on = (tx_ext_div_ff != 8'h00);
    assign rx_ext_on = (rx_ext_div_ff != 8'h00);
    assign sixteen_wrap = (sixteen_ff == SIXTEEN_DIV_TOP);
    assign st_hit = (i_addr == OFF_STATUS) && (i_rd || i_wr);
    assign rd_data = i_rd && (i_addr == OFF_CHAR_DATA);
    assign wr_data = i_wr && (i_addr == OFF_CHAR_DATA);

    // Configuration registers
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            rate_select_ff <= RATE_SELECT_RST;
            rx_ext_div_ff <= EXT_DIV_RST;
            tx_ext_div_ff <= EXT_DIV_RST;
            mask_ff <= 2'h0;
        end else if (i_wr) begin
            case (i_addr)
                OFF_RATE_SELECT: rate_select_ff <= i_wdata;
                OFF_RX_EXT_DIV: rx_ext_div_ff <= i_wdata;
                OFF_TX_EXT_DIV: tx_ext_div_ff <= i_wdata;
                OFF_IRQ_MASK: mask_ff <= i_wdata[1:0];
                default: ;
            endcase
        end
    end

    // Transmit holding register, loaded only by writes
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            tx_holding_ff <= 8'h00;
        end else if (wr_data) begin
            tx_holding_ff <= i_wdata;
        end
    end

    // Receive holding register, filled from the input shifter
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            rx_holding_ff <= 8'h00;
        end else if (i_rx_done) begin
            rx_holding_ff <= i_rx_byte;
        end
    end

    // Mute: software write, hardware wake clear wins over a set
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            mute_ff <= 1'b0;
        end else if (i_wake) begin
            mute_ff <= 1'b0;
        end else if (i_wr && i_addr == OFF_CONTROL) begin
            mute_ff <= i_wdata[CTL_MUTE_BIT];
        end
    end

    // Break level and the one-word break after a set-then-clear
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            break_ff <= 1'b0;
            break_pend_ff <= 1'b0;
            break_once_ff <= 1'b0;
        end else begin
            if (i_wr && i_addr == OFF_CONTROL) begin
                break_ff <= i_wdata[CTL_BREAK_BIT];
            end
            // A falling edge of the bit arms a single break word
            if (i_wr && i_addr == OFF_CONTROL && break_ff && !i_wdata[CTL_BREAK_BIT]) begin
                break_pend_ff <= 1'b1;
            end else if (break_pend_ff && i_word_end) begin
                break_pend_ff <= 1'b0;
            end
            break_once_ff <= break_pend_ff && i_word_end;
        end
    end

    // Status-access tracking for the clear sequences
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            acc_ff <= ACC_IDLE;
        end else if (st_hit) begin
            acc_ff <= ACC_STATUS_SEEN;
        end else if (wr_data || rd_data) begin
            acc_ff <= ACC_IDLE;
        end
    end

    // Flags: a hardware set in the clearing cycle wins
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            status_ff <= STATUS_RST[1:0];
        end else begin
            if (i_tx_load) begin
                status_ff[ST_TX_EMPTY_BIT] <= 1'b1;
            end else if (wr_data && acc_ff == ACC_STATUS_SEEN) begin
                status_ff[ST_TX_EMPTY_BIT] <= 1'b0;
            end
            if (i_rx_done) begin
                status_ff[ST_RX_FULL_BIT] <= 1'b1;
            end else if (rd_data && acc_ff == ACC_STATUS_SEEN) begin
                status_ff[ST_RX_FULL_BIT] <= 1'b0;
            end
        end
    end

    // Conventional dividers, one per path
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            tx_cnt_ff <= '0;
            rx_cnt_ff <= '0;
        end else begin
            tx_cnt_ff <= (tx_cnt_ff >= conv_top(pre_sel, tx_sel)) ? '0 : tx_cnt_ff + 1'b1;
            rx_cnt_ff <= (rx_cnt_ff >= conv_top(pre_sel, rx_sel)) ? '0 : rx_cnt_ff + 1'b1;
        end
    end

    // Shared divide-by-16 stage feeding both extended dividers
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            sixteen_ff <= 4'h0;
            tx_ext_cnt_ff <= 8'h00;
            rx_ext_cnt_ff <= 8'h00;
        end else begin
            sixteen_ff <= sixteen_ff + 4'h1;
            if (sixteen_wrap) begin
                tx_ext_cnt_ff <= (tx_ext_cnt_ff + 8'h01 >= tx_ext_div_ff) ? 8'h00
                                 : tx_ext_cnt_ff + 8'h01;
                rx_ext_cnt_ff <= (rx_ext_cnt_ff + 8'h01 >= rx_ext_div_ff) ? 8'h00
                                 : rx_ext_cnt_ff + 8'h01;
            end
        end
    end

    // Rate ticks: extended path overrides conventional when nonzero
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            tx_tick_ff <= 1'b0;
            rx_tick_ff <= 1'b0;
        end else begin
            tx_tick_ff <= tx_ext_on ? (sixteen_wrap && tx_ext_cnt_ff + 8'h01 >= tx_ext_div_ff)
                                    : (tx_cnt_ff >= conv_top(pre_sel, tx_sel));
            rx_tick_ff <= rx_ext_on ? (sixteen_wrap && rx_ext_cnt_ff + 8'h01 >= rx_ext_div_ff)
                                    : (rx_cnt_ff >= conv_top(pre_sel, rx_sel));
        end
    end

    // Read data one cycle after the strobe; unmapped reads return zero
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            rdata_ff <= 8'h00;
        end else if (i_rd) begin
            case (i_addr)
                OFF_CHAR_DATA: rdata_ff <= rx_holding_ff;
                OFF_RATE_SELECT: rdata_ff <= rate_select_ff;
                OFF_RX_EXT_DIV: rdata_ff <= rx_ext_div_ff;
                OFF_TX_EXT_DIV: rdata_ff <= tx_ext_div_ff;
                OFF_CONTROL: rdata_ff <= {6'h00, mute_ff, break_ff};
                OFF_STATUS: rdata_ff <= {6'h00, status_ff};
                OFF_IRQ_MASK: rdata_ff <= {6'h00, mask_ff};
                default: rdata_ff <= 8'h00;
            endcase
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    assign o_rdata = rdata_ff;
    assign o_tx_byte = tx_holding_ff;
    assign o_tx_rate_tick = tx_tick_ff;
    assign o_rx_rate_tick = rx_tick_ff;
    assign o_break_level = break_ff;
    assign o_break_once = break_once_ff;
    assign o_mute = mute_ff;
    // Level interrupt while any unmasked flag stands
    assign o_irq = |(status_ff & mask_ff);

    // Checks kept next to the logic they guard
    a_wake_clears_mute: assert property (@(posedge i_clock) disable iff (i_reset)
        i_wake |=> !o_mute) else $error("mute not cleared by wake");
    a_break_follows_bit: assert property (@(posedge i_clock) disable iff (i_reset)
        (i_wr && i_addr == OFF_CONTROL) |=> (o_break_level == $past(i_wdata[CTL_BREAK_BIT])))
        else $error("break level does not follow write");
    a_break_once_word: assert property (@(posedge i_clock) disable iff (i_reset)
        o_break_once |-> $past(i_word_end)) else $error("break word outside word end");
    a_data_write_tx: assert property (@(posedge i_clock) disable iff (i_reset)
        wr_data |=> o_tx_byte == $past(i_wdata)) else $error("tx holding not loaded");
    a_data_read_rx: assert property (@(posedge i_clock) disable iff (i_reset)
        (rd_data && !i_rx_done) |=> o_rdata == $past(rx_holding_ff))
        else $error("data read not rx holding");
    // First edge after release only: the very first edge still sees unreset flops
    a_ext_reset_zero: assert property (@(posedge i_clock)
        (!i_reset && $past(i_reset)) |-> (!tx_ext_on && !rx_ext_on))
        else $error("extended not zero after reset");
    a_tx_empty_set: assert property (@(posedge i_clock) disable iff (i_reset)
        i_tx_load |=> status_ff[ST_TX_EMPTY_BIT]) else $error("tx empty not set");
    a_rx_full_set: assert property (@(posedge i_clock) disable iff (i_reset)
        i_rx_done |=> status_ff[ST_RX_FULL_BIT]) else $error("rx full not set");
    a_conv_unity_tick: assert property (@(posedge i_clock) disable iff (i_reset)
        (!tx_ext_on && pre_sel == 2'b00 && tx_sel == 3'b000) [*3] |-> o_tx_rate_tick)
        else $error("unity divide not every cycle");
    // Leading cycle keeps an extended-path tick from posing as a conventional one
    a_prescale_three: assert property (@(posedge i_clock) disable iff (i_reset)
        (!tx_ext_on && pre_sel == 2'b01 && tx_sel == 3'b000) ##1
        (!tx_ext_on && pre_sel == 2'b01 && tx_sel == 3'b000 && o_tx_rate_tick) ##1
        (pre_sel == 2'b01 && tx_sel == 3'b000 && !tx_ext_on) [*3] |-> o_tx_rate_tick)
        else $error("prescale three period wrong");
    // Software mute write lands unless a wake arrives in the same cycle
    a_mute_write: assert property (@(posedge i_clock) disable iff (i_reset)
        (i_wr && i_addr == OFF_CONTROL && !i_wake) |=> (o_mute == $past(i_wdata[CTL_MUTE_BIT])))
        else $error("mute write not applied");
    // Clearing the break bit arms exactly one break word
    a_break_arm: assert property (@(posedge i_clock) disable iff (i_reset)
        (i_wr && i_addr == OFF_CONTROL && o_break_level && !i_wdata[CTL_BREAK_BIT])
        |=> break_pend_ff) else $error("break word not armed");
    a_break_word_end: assert property (@(posedge i_clock) disable iff (i_reset)
        (break_pend_ff && i_word_end) |=> o_break_once)
        else $error("armed break word not sent");
    // Software clear sequences, when no hardware set competes
    a_tx_empty_clear: assert property (@(posedge i_clock) disable iff (i_reset)
        (wr_data && acc_ff == ACC_STATUS_SEEN && !i_tx_load) |=> !status_ff[ST_TX_EMPTY_BIT])
        else $error("tx empty not cleared");
    a_rx_full_clear: assert property (@(posedge i_clock) disable iff (i_reset)
        (rd_data && acc_ff == ACC_STATUS_SEEN && !i_rx_done) |=> !status_ff[ST_RX_FULL_BIT])
        else $error("rx full not cleared");
    // Receive path at unity factors ticks on every cycle
    a_rx_unity_tick: assert property (@(posedge i_clock) disable iff (i_reset)
        (!rx_ext_on && pre_sel == 2'b00 && rx_sel == 3'b000) [*2] |-> o_rx_rate_tick)
        else $error("rx unity divide not every cycle");
    // A conventional tick above unity is never followed by another at once
    a_tx_no_double: assert property (@(posedge i_clock) disable iff (i_reset)
        (!tx_ext_on && (pre_sel != 2'b00 || tx_sel != 3'b000)) ##1
        (!tx_ext_on && (pre_sel != 2'b00 || tx_sel != 3'b000) && o_tx_rate_tick)
        |=> !o_tx_rate_tick) else $error("tx tick too close");
    a_rx_no_double: assert property (@(posedge i_clock) disable iff (i_reset)
        (!rx_ext_on && (pre_sel != 2'b00 || rx_sel != 3'b000)) ##1
        (!rx_ext_on && (pre_sel != 2'b00 || rx_sel != 3'b000) && o_rx_rate_tick)
        |=> !o_rx_rate_tick) else $error("rx tick too close");
    // Extended ticks only ever follow the last count of the sixteen stage
    a_tx_ext_wrap: assert property (@(posedge i_clock) disable iff (i_reset)
        ($past(tx_ext_on) && sixteen_ff != 4'h0) |-> !o_tx_rate_tick)
        else $error("tx extended tick off the sixteen stage");
    a_rx_ext_wrap: assert property (@(posedge i_clock) disable iff (i_reset)
        ($past(rx_ext_on) && sixteen_ff != 4'h0) |-> !o_rx_rate_tick)
        else $error("rx extended tick off the sixteen stage");
endmodule

// *** verif/shift_engine_model.sv ***
// Behavioural shift engine beside the serial rate block.
// Assumes the bench commands receive, wake and word traffic.
`timescale 1ns/1ps
module shift_engine_model (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_reset,
    // Commands from the bench
    input wire logic i_run,
    input wire logic i_cmd_rx,
    input wire logic [7:0] i_cmd_byte,
    input wire logic i_cmd_wake,
    // Rate tick from the block
    input wire logic i_tx_tick,
    // Events toward the block
    output logic o_tx_load,
    output logic o_rx_done,
    output logic [7:0] o_rx_byte,
    output logic o_wake,
    output logic o_word_end
);
    logic [3:0] bit_cnt_ff;
    // A word lasts ten rate ticks; its end also pulls the next byte in
    always_ff @(posedge i_clock) begin
        if (i_reset || !i_run) begin
            bit_cnt_ff <= 4'h0;
            o_word_end <= 1'b0;
            o_tx_load <= 1'b0;
        end else begin
            o_word_end <= i_tx_tick && bit_cnt_ff == 4'h9;
            o_tx_load <= i_tx_tick && bit_cnt_ff == 4'h9;
            if (i_tx_tick) begin
                bit_cnt_ff <= (bit_cnt_ff == 4'h9) ? 4'h0 : bit_cnt_ff + 4'h1;
            end
        end
    end
    // Byte valid only with its strobe; junk that toggles otherwise
    always_ff @(posedge i_clock) begin
        o_rx_done <= i_cmd_rx && !i_reset;
        o_wake <= i_cmd_wake && !i_reset;
        o_rx_byte <= i_cmd_rx ? i_cmd_byte : (i_reset ? 8'hA5 : ~o_rx_byte);
    end
endmodule

// *** verif/tb.sv ***
// Self-checking bench for the serial rate and control block.
// Assumes the shift engine model on the event side and a 25 MHz clock.
`timescale 1ns/1ps
module tb;
    import serial_rate_pkg::*;
    logic i_clock = 1'b0;
    logic i_reset = 1'b1;
    logic [3:0] i_addr = 4'h0;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic run = 1'b0;
    logic cmd_rx = 1'b0;
    logic cmd_wake = 1'b0;
    logic [7:0] cmd_byte = 8'h00;
    logic [7:0] rdv, b, o_rdata, o_tx_byte, rx_byte;
    logic o_tx_rate_tick, o_rx_rate_tick, o_break_level, o_break_once, o_mute, o_irq;
    logic tx_load, rx_done, wake, word_end;
    logic [1:0] p;
    logic [2:0] t, r;
    int err_count = 0;
    int num_checks = 0;
    int cycles = 0;
    int n;

    serial_rate_ctl serial_rate_ctl_i (.i_clock(i_clock), .i_reset(i_reset), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_tx_load(tx_load),
        .i_rx_done(rx_done), .i_rx_byte(rx_byte), .i_wake(wake), .i_word_end(word_end),
        .o_tx_byte(o_tx_byte), .o_tx_rate_tick(o_tx_rate_tick), .o_rx_rate_tick(o_rx_rate_tick),
        .o_break_level(o_break_level), .o_break_once(o_break_once), .o_mute(o_mute),
        .o_irq(o_irq));
    shift_engine_model shift_engine_model_i (.i_clock(i_clock), .i_reset(i_reset), .i_run(run),
        .i_cmd_rx(cmd_rx), .i_cmd_byte(cmd_byte), .i_cmd_wake(cmd_wake),
        .i_tx_tick(o_tx_rate_tick), .o_tx_load(tx_load), .o_rx_done(rx_done),
        .o_rx_byte(rx_byte), .o_wake(wake), .o_word_end(word_end));

    always #20 i_clock = ~i_clock;

    // Watchdog well above the longest rate sweep
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 40000) begin
            err_count++;
            $display("Error %0t: timeout", $time);
            complete_run();
        end
    end

    task automatic complete_run();
        if (err_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clock);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge i_clock);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask

    // Cycles between the second and third tick, so old settings flush out
    task automatic period(input bit rx, output int cnt);
        int k;
        k = 0;
        cnt = 0;
        while (k < 3) begin
            @(negedge i_clock);
            if (k == 2) cnt++;
            if ((rx ? o_rx_rate_tick : o_tx_rate_tick) === 1'b1) k++;
        end
    endtask

    function automatic int conv(input logic [1:0] pc, input logic [2:0] c);
        int f;
        f = (pc == 2'h0) ? 1 : (pc == 2'h1) ? 3 : (pc == 2'h2) ? 4 : 13;
        return f << c;
    endfunction

    task automatic event_pulse(input bit is_rx, input logic [7:0] d);
        @(posedge i_clock);
        cmd_rx <= is_rx;
        cmd_wake <= !is_rx;
        cmd_byte <= d;
        @(posedge i_clock);
        cmd_rx <= 1'b0;
        cmd_wake <= 1'b0;
        repeat (2) @(posedge i_clock);
    endtask

    initial begin
        void'($urandom(32'h9B91));
        repeat (4) @(posedge i_clock);
        i_reset <= 1'b0;
        // Reset values, unmapped offset reads zero
        rd(OFF_RX_EXT_DIV, rdv); chk(rdv, 8'h00);
        rd(OFF_TX_EXT_DIV, rdv); chk(rdv, 8'h00);
        rd(4'hF, rdv); chk(rdv, 8'h00);
        rd(OFF_STATUS, rdv); chk(rdv, STATUS_RST);
        // Conventional rates: every prescale code, random and extreme path codes
        for (int i = 0; i < 6; i++) begin
            p = i[1:0];
            t = 3'($urandom_range(3));
            r = 3'($urandom_range(3));
            if (i == 4) {t, r} = {3'h7, 3'h0};
            if (i == 5) {t, r} = {3'h0, 3'h7};
            wr(OFF_RATE_SELECT, {p, t, r});
            period(1'b0, n); chk(n, conv(p, t));
            period(1'b1, n); chk(n, conv(p, r));
        end
        // Extended dividers override the conventional path
        for (int j = 0; j < 3; j++) begin
            b = (j == 0) ? 8'h23 : (j == 1) ? 8'h01 : 8'($urandom_range(20, 2));
            wr(OFF_RX_EXT_DIV, b);
            wr(OFF_TX_EXT_DIV, b + 8'h01);
            rd(OFF_RX_EXT_DIV, rdv); chk(rdv, b);
            period(1'b1, n); chk(n, 16 * b);
            period(1'b0, n); chk(n, 16 * (b + 8'h01));
        end
        wr(OFF_RX_EXT_DIV, 8'h00);
        wr(OFF_TX_EXT_DIV, 8'h00);
        period(1'b0, n); chk(n, conv(p, t));
        // Flags, data holding and interrupt mask
        wr(OFF_IRQ_MASK, 8'h03);
        @(negedge i_clock); chk(o_irq, 1'b1);
        b = 8'($urandom);
        rd(OFF_STATUS, rdv);
        wr(OFF_CHAR_DATA, b);
        @(negedge i_clock); chk(o_tx_byte, b);
        rd(OFF_STATUS, rdv); chk(rdv, 8'h02);
        rd(OFF_CHAR_DATA, rdv);
        rd(OFF_STATUS, rdv); chk(rdv, 8'h00);
        chk(o_irq, 1'b0);
        b = 8'($urandom);
        event_pulse(1'b1, b);
        @(negedge i_clock); chk(o_irq, 1'b1);
        rd(OFF_STATUS, rdv); chk(rdv, 8'h02);
        // Mask off the standing receive flag; the clear sequence still holds
        wr(OFF_IRQ_MASK, 8'h01);
        @(negedge i_clock); chk(o_irq, 1'b0);
        rd(OFF_CHAR_DATA, rdv); chk(rdv, b);
        // Mute set by software write, cleared by a wake event
        wr(OFF_CONTROL, 8'h02);
        @(negedge i_clock); chk(o_mute, 1'b1);
        event_pulse(1'b0, 8'h00);
        @(negedge i_clock); chk(o_mute, 1'b0);
        // Break set then cleared with words in flight
        wr(OFF_RATE_SELECT, 8'h00);
        run <= 1'b1;
        wr(OFF_CONTROL, 8'h01);
        @(negedge i_clock); chk(o_break_level, 1'b1);
        wr(OFF_CONTROL, 8'h00);
        @(negedge i_clock); chk(o_break_level, 1'b0);
        while (word_end !== 1'b1) @(negedge i_clock);
        @(negedge i_clock); chk(o_break_once, 1'b1);
        @(negedge i_clock); chk(o_break_once, 1'b0);
        rd(OFF_STATUS, rdv); chk(rdv[ST_TX_EMPTY_BIT], 1'b1);
        complete_run();
    end
endmodule
